// *** verilog/dftm_pkg.sv ***
/*
  Constants and types of the drive fault-trip manager: source indices,
  hold classes, register offsets, field positions and timing figures.
  Assumes a single 50 MHz system clock.
*/
package dftm_pkg;

  localparam int NSRC = 17;
  localparam int CW = 5;

  // Source index is also its display code; lower index wins
  localparam int FI_OCT = 0;
  localparam int FI_OVT = 1;
  localparam int FI_GFT = 2;
  localparam int FI_LVT = 3;
  localparam int FI_LV2 = 4;
  localparam int FI_IOL = 5;
  localparam int FI_ETH = 6;
  localparam int FI_POT = 7;
  localparam int FI_IPO = 8;
  localparam int FI_OLT = 9;
  localparam int FI_ULT = 10;
  localparam int FI_NMT = 11;
  localparam int FI_ROT = 12;
  localparam int FI_OVER_TORQUE_FIRST_TRIP = 13;
  localparam int FI_OVER_TORQUE_SECOND_TRIP = 14;
  localparam int FI_UNDER_TORQUE_FIRST_TRIP = 15;
  localparam int FI_UNDER_TORQUE_SECOND_TRIP = 16;

  localparam logic [NSRC-1:0] CLS_LEVEL = 17'h00008;
  localparam logic [NSRC-1:0] CLS_FATAL = 17'h00000;
  localparam logic [CW-1:0] NO_FAULT_CODE = 5'h1f;

  // Byte addresses of the register port
  localparam logic [7:0] ADDR_EN = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_TQ = 8'h08;
  localparam logic [7:0] ADDR_LVL = 8'h0c;
  localparam logic [7:0] ADDR_WARN = 8'h10;
  localparam logic [7:0] ADDR_ACT = 8'h14;
  localparam logic [7:0] ADDR_DISP = 8'h18;
  localparam logic [7:0] ADDR_HIST = 8'h1c;

  localparam int PHASE_OUT_BIT = 1;
  localparam int PHASE_IN_BIT = 2;
  localparam logic [7:0] PARAM_ONE = 8'h01;
  localparam logic [3:0] TQ_OVER_A = 4'h3;
  localparam logic [3:0] TQ_OVER_B = 4'h4;
  localparam logic [3:0] TQ_UNDER_A = 4'h7;
  localparam logic [3:0] TQ_UNDER_B = 4'h8;

  localparam int CLK_NS = 20;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_NS;

  // Drive overload budget, in millisecond units of full rate
  localparam int AW = 17;
  localparam logic [7:0] PCT_100 = 8'h64;
  localparam logic [7:0] PCT_120 = 8'h78;
  localparam logic [7:0] PCT_150 = 8'h96;
  localparam logic [7:0] PCT_200 = 8'hc8;
  localparam int OL_T150_MS = 60000;
  localparam int OL_T200_MS = 4000;
  localparam int OL_T200L_MS = 2000;
  localparam logic [AW-1:0] OL_LIM = AW'(OL_T150_MS);
  localparam logic [AW-1:0] OL_INC_HI = AW'(OL_T150_MS / OL_T200_MS);
  localparam logic [AW-1:0] OL_INC_HIL = AW'(OL_T150_MS / OL_T200L_MS);
  localparam logic [AW-1:0] ETH_LIM = AW'(60000);

  typedef struct packed {
    logic fault_reset;
    logic overcurrent;
    logic overvoltage;
    logic undervoltage;
    logic ground_fault;
    logic out_phase_open;
    logic in_phase_open;
    logic motor_absent;
    logic relay_fail;
    logic running;
    logic light_duty;
    logic [7:0] load_pct;
    logic [7:0] current_pct;
  } dftm_sens_s;

  localparam int SENS_W = $bits(dftm_sens_s);

endpackage

// *** verilog/dftm_top.sv ***
/*
  Drive fault-trip manager: conditions each monitor input, holds each
  trip by its class, keeps a short fault history and the display code.
  Assumes sensing inputs and the operator reset are asynchronous pins,
  and that resetn is the power-on reset of the whole drive.
*/
`timescale 1ns/10ps

// Operation
// - Enabled fault either halts the drive or raises a warning, per source.
// - Simultaneous trips show only the highest priority code.
// - Level faults clear with their condition and never enter history.
// - Latch faults clear only after condition gone plus a reset input.
// - Fatal faults survive reset input; only power-on reset clears them.
// - With no fault active the display shows the no-fault code.
// - Motor overload, latch, load above level, enable nonzero.
// - Motor underload, latch, load below level, enable nonzero.
// - Latch overcurrent trip from the output-current monitor.
// - Latch overvoltage trip from the DC-bus monitor.
// - Level undervoltage fault from the DC-bus monitor.
// - Latch running undervoltage trip when its parameter equals one.
// - Latch inverse-time motor thermal trip, enable nonzero.
// - Latch output phase-open trip when config bit one set.
// - Latch input phase-open trip when config bit two set.
// - Drive overload: 150% 1 min, 200% 4 s; light 120%, 200% 2 s.
// - Latch no-motor trip while running when its enable equals one.
// - First over-torque trip, current above level one, mode 3 or 4.
// - Second over-torque trip, current above level two, mode 3 or 4.
// - First under-torque trip, current below level one, mode 7 or 8.
// - Second under-torque trip, current below level two, mode 7 or 8.
// - Latch relay-open trip at power-up when relay check equals one.
module dftm_top
  import dftm_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire dftm_sens_s sens_pins,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  output logic trip_halt,
  output logic warning_out,
  output logic [CW-1:0] display_code
);

  // Input conditioning: three stages, accept when stages two and three agree
  // The agreement stage filters one-cycle glitches on the pins;
  // the cost is one more edge of latency on every fault path.
  logic [SENS_W-1:0] sy1_r;
  logic [SENS_W-1:0] sy2_r;
  logic [SENS_W-1:0] sy3_r;
  logic [SENS_W-1:0] syq_r;
  dftm_sens_s sn;

  genvar b;
  generate
    for (b = 0; b < SENS_W; b++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!resetn) begin
          sy1_r[b] <= 1'b0;
          sy2_r[b] <= 1'b0;
          sy3_r[b] <= 1'b0;
          syq_r[b] <= 1'b0;
        end else begin
          sy1_r[b] <= sens_pins[b];
          sy2_r[b] <= sy1_r[b];
          sy3_r[b] <= sy2_r[b];
          if (sy2_r[b] == sy3_r[b]) begin
            syq_r[b] <= sy3_r[b];
          end
        end
      end
    end
  endgenerate

  assign sn = dftm_sens_s'(syq_r);

  // A held reset must not clear a fault that comes back later
  logic rst_d_r;
  wire rst_edge = sn.fault_reset & ~rst_d_r;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rst_d_r <= 1'b0;
    end else begin
      rst_d_r <= sn.fault_reset;
    end
  end

  // Parameter registers
  // Fields with no meaning read back as written, except warning-mask bits
  // above the sources, which read as zero; the read path stays a plain selection.
  logic [31:0] en_r;
  logic [31:0] cfg_r;
  logic [31:0] tq_r;
  logic [31:0] lvl_r;
  logic [NSRC-1:0] warn_mask_r;

  wire [7:0] overload_enable_param = en_r[7:0];
  wire [7:0] underload_enable_param = en_r[15:8];
  wire [7:0] thermal_enable_param = en_r[23:16];
  wire [7:0] no_motor_enable_param = en_r[31:24];
  wire [7:0] run_undervolt_enable_param = cfg_r[7:0];
  wire [7:0] phase_loss_config_param = cfg_r[15:8];
  wire [7:0] relay_check_param = cfg_r[23:16];
  wire [3:0] torque_mode_first = tq_r[3:0];
  wire [3:0] torque_mode_second = tq_r[7:4];
  wire [7:0] torque_level_first = tq_r[15:8];
  wire [7:0] torque_level_second = tq_r[23:16];
  wire [7:0] overload_level = lvl_r[7:0];
  wire [7:0] underload_level = lvl_r[15:8];
  wire [7:0] thermal_level = lvl_r[23:16];

  wire wr_en = reg_we & (reg_addr == ADDR_EN);
  wire wr_cfg = reg_we & (reg_addr == ADDR_CFG);
  wire wr_tq = reg_we & (reg_addr == ADDR_TQ);
  wire wr_lvl = reg_we & (reg_addr == ADDR_LVL);
  wire wr_warn = reg_we & (reg_addr == ADDR_WARN);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      en_r <= 32'h0;
      cfg_r <= 32'h0;
      tq_r <= 32'h0;
      lvl_r <= 32'h0;
      warn_mask_r <= '0;
    end else begin
      if (wr_en) en_r <= reg_wdata;
      if (wr_cfg) cfg_r <= reg_wdata;
      if (wr_tq) tq_r <= reg_wdata;
      if (wr_lvl) lvl_r <= reg_wdata;
      if (wr_warn) warn_mask_r <= reg_wdata[NSRC-1:0];
    end
  end

  // Millisecond enable for the inverse-time accumulators
  // One shared tick keeps both accumulators on the same time base.
  // The counter width bounds the largest usable MS_CYCLES value.
  logic [16:0] ms_cnt_r;
  wire ms_tick = (ms_cnt_r == 17'(MS_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ms_cnt_r <= 17'h0;
    end else if (ms_tick) begin
      ms_cnt_r <= 17'h0;
    end else begin
      ms_cnt_r <= ms_cnt_r + 17'h1;
    end
  end

  // Drive overload budget; rate steps give the two fixed endurance points
  // Below the knee the budget drains one unit per tick, so a drive that
  // ran hot recovers slowly, much like a warm heat sink.
  // Clipping at the limit keeps that recovery time bounded.
  logic [AW-1:0] iol_acc_r;
  logic [AW-1:0] iol_acc_nxt;
  wire [7:0] ol_knee = sn.light_duty ? PCT_120 : PCT_150;
  wire [AW-1:0] ol_hi_inc = sn.light_duty ? OL_INC_HIL : OL_INC_HI;
  wire ol_hi = sn.load_pct >= PCT_200;
  wire ol_mid = sn.load_pct >= ol_knee;

  always_comb begin
    iol_acc_nxt = iol_acc_r;
    if (ol_hi) begin
      iol_acc_nxt = iol_acc_r + ol_hi_inc;
    end else if (ol_mid) begin
      iol_acc_nxt = iol_acc_r + AW'(1);
    end else if (iol_acc_r != '0) begin
      iol_acc_nxt = iol_acc_r - AW'(1);
    end
    if (iol_acc_nxt > OL_LIM) begin
      iol_acc_nxt = OL_LIM;
    end
  end

  // Motor thermal: heating rate grows with the excess over the level
  // Disabling the trip empties the accumulator, so enabling it later
  // starts from a cold motor.
  logic [AW-1:0] eth_acc_r;
  logic [AW-1:0] eth_acc_nxt;
  wire eth_on = thermal_enable_param != 8'h0;
  wire eth_hot = sn.load_pct > thermal_level;
  wire [7:0] eth_excess = sn.load_pct - thermal_level;

  always_comb begin
    eth_acc_nxt = eth_acc_r;
    if (!eth_on) begin
      eth_acc_nxt = '0;
    end else if (eth_hot) begin
      eth_acc_nxt = eth_acc_r + AW'(eth_excess);
    end else if (eth_acc_r != '0) begin
      eth_acc_nxt = eth_acc_r - AW'(1);
    end
    if (eth_acc_nxt > ETH_LIM) begin
      eth_acc_nxt = ETH_LIM;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      iol_acc_r <= '0;
      eth_acc_r <= '0;
    end else if (ms_tick) begin
      iol_acc_r <= iol_acc_nxt;
      eth_acc_r <= eth_acc_nxt;
    end
  end

  // Relay check only means something just after power-up
  logic pwr_up_r;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pwr_up_r <= 1'b1;
    end else if (ms_tick) begin
      pwr_up_r <= 1'b0;
    end
  end

  // Qualified fault conditions
  // Each source that has a parameter is gated here by it, so the hold logic
  // below never needs to know which parameter belongs to which trip.
  wire tq1_over = (torque_mode_first == TQ_OVER_A) |
                  (torque_mode_first == TQ_OVER_B);
  wire tq2_over = (torque_mode_second == TQ_OVER_A) |
                  (torque_mode_second == TQ_OVER_B);
  wire tq1_under = (torque_mode_first == TQ_UNDER_A) |
                   (torque_mode_first == TQ_UNDER_B);
  wire tq2_under = (torque_mode_second == TQ_UNDER_A) |
                   (torque_mode_second == TQ_UNDER_B);
  logic [NSRC-1:0] cond;

  always_comb begin
    cond = '0;
    cond[FI_OCT] = sn.overcurrent;
    cond[FI_OVT] = sn.overvoltage;
    cond[FI_GFT] = sn.ground_fault;
    cond[FI_LVT] = sn.undervoltage;
    cond[FI_LV2] = sn.undervoltage & sn.running &
                   (run_undervolt_enable_param == PARAM_ONE);
    cond[FI_IOL] = iol_acc_r >= OL_LIM;
    cond[FI_ETH] = eth_on & (eth_acc_r >= ETH_LIM);
    cond[FI_POT] = sn.out_phase_open &
                   phase_loss_config_param[PHASE_OUT_BIT];
    cond[FI_IPO] = sn.in_phase_open &
                   phase_loss_config_param[PHASE_IN_BIT];
    cond[FI_OLT] = (overload_enable_param != 8'h0) &
                   (sn.load_pct > overload_level);
    cond[FI_ULT] = (underload_enable_param != 8'h0) &
                   (sn.load_pct < underload_level);
    cond[FI_NMT] = sn.motor_absent & sn.running &
                   (no_motor_enable_param == PARAM_ONE);
    cond[FI_ROT] = sn.relay_fail & pwr_up_r &
                   (relay_check_param == PARAM_ONE);
    cond[FI_OVER_TORQUE_FIRST_TRIP] = tq1_over &
                    (sn.current_pct > torque_level_first);
    cond[FI_OVER_TORQUE_SECOND_TRIP] = tq2_over &
                    (sn.current_pct > torque_level_second);
    cond[FI_UNDER_TORQUE_FIRST_TRIP] = tq1_under &
                    (sn.current_pct < torque_level_first);
    cond[FI_UNDER_TORQUE_SECOND_TRIP] = tq2_under &
                    (sn.current_pct < torque_level_second);
  end

  // Per-source hold by class
  // Class comes from two package masks; a fatal source ignores the
  // operator reset entirely and only power-on reset clears it.
  logic [NSRC-1:0] held_r;
  logic [NSRC-1:0] held_nxt;

  genvar i;
  generate
    for (i = 0; i < NSRC; i++) begin : g_hold
      always_comb begin
        if (CLS_FATAL[i]) begin
          held_nxt[i] = held_r[i] | cond[i];
        end else if (CLS_LEVEL[i]) begin
          held_nxt[i] = cond[i];
        end else begin
          // New condition wins over a reset edge in the same cycle
          held_nxt[i] = cond[i] | (held_r[i] & ~rst_edge);
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      held_r <= '0;
    end else begin
      held_r <= held_nxt;
    end
  end

  function automatic logic [CW-1:0] first_code(input logic [NSRC-1:0] v);
    logic [CW-1:0] c;
    c = NO_FAULT_CODE;
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (v[k]) c = CW'(k);
    end
    return c;
  endfunction

  // History: only latch and fatal onsets, top priority per cycle
  // Onsets of several sources in one cycle keep only the top one;
  // a wider history would cost a priority queue for little gain.
  wire [NSRC-1:0] onset = held_nxt & ~held_r & ~CLS_LEVEL;
  wire [CW-1:0] onset_code = first_code(onset);
  logic [4*CW-1:0] hist_r;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      hist_r <= {4{NO_FAULT_CODE}};
    end else if (onset != '0) begin
      hist_r <= {hist_r[3*CW-1:0], onset_code};
    end
  end

  // Outputs and readouts
  // Outputs follow held_nxt so they come one edge earlier than a
  // copy of held_r would give them.
  wire [NSRC-1:0] warn_act = held_nxt & warn_mask_r;
  wire [NSRC-1:0] trip_act = held_nxt & ~warn_mask_r;
  logic [CW-1:0] warning_readout_param;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      trip_halt <= 1'b0;
      warning_out <= 1'b0;
      display_code <= NO_FAULT_CODE;
      warning_readout_param <= NO_FAULT_CODE;
    end else begin
      trip_halt <= |trip_act;
      warning_out <= |warn_act;
      display_code <= first_code(held_nxt);
      warning_readout_param <= first_code(warn_act);
    end
  end

  // Register read: data only in the cycle after the strobe
  // Idle cycles return zero so a stale word is never taken for
  // fresh read data.
  logic [31:0] rd_mux;
  wire [31:0] disp_word = {19'h0, warning_readout_param, 3'h0,
                           display_code};

  always_comb begin
    unique case (reg_addr)
      ADDR_EN: rd_mux = en_r;
      ADDR_CFG: rd_mux = cfg_r;
      ADDR_TQ: rd_mux = tq_r;
      ADDR_LVL: rd_mux = lvl_r;
      ADDR_WARN: rd_mux = 32'(warn_mask_r);
      ADDR_ACT: rd_mux = 32'(held_r);
      ADDR_DISP: rd_mux = disp_word;
      ADDR_HIST: rd_mux = 32'(hist_r);
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reg_rdata <= 32'h0;
    end else if (reg_re) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 32'h0;
    end
  end

endmodule

// *** dv/dftm_checker.sv ***
/*
  Port assertions of the drive fault-trip manager.
  Bound to dftm_top from the bench; one clock, synchronous reset.
*/
`timescale 1ns/10ps
module dftm_checker
  import dftm_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire dftm_sens_s sens_pins,
  input wire logic reg_re,
  input wire logic [31:0] reg_rdata,
  input wire logic trip_halt,
  input wire logic warning_out,
  input wire logic [CW-1:0] display_code
);
  default clocking cb @(posedge core_clk);
  endclocking
  wire logic any_out = trip_halt | warning_out;
  // Seven samples leave one edge of slack over the five-edge latency
  a_no_fault: assert property (disable iff (!resetn)
    (display_code == NO_FAULT_CODE) == !any_out)
    else $error("display code and flags disagree");
  a_code_range: assert property (disable iff (!resetn)
    display_code < CW'(NSRC) || display_code == NO_FAULT_CODE)
    else $error("display code out of range");
  a_oct_trip: assert property (disable iff (!resetn)
    sens_pins.overcurrent [*7] |-> display_code == CW'(FI_OCT))
    else $error("overcurrent not shown");
  a_ovt_trip: assert property (disable iff (!resetn)
    sens_pins.overvoltage [*7] |-> display_code <= CW'(FI_OVT))
    else $error("overvoltage not shown");
  a_uv_level: assert property (disable iff (!resetn)
    sens_pins.undervoltage [*7] |-> display_code <= CW'(FI_LVT))
    else $error("undervoltage not shown");
  a_level_clear: assert property (disable iff (!resetn)
    (!sens_pins.undervoltage) [*7] |-> display_code != CW'(FI_LVT))
    else $error("level fault outlived its condition");
  a_latch_hold: assert property (disable iff (!resetn)
    $stable(sens_pins.fault_reset) [*7] ##0 display_code == CW'(FI_OCT)
    |=> display_code == CW'(FI_OCT))
    else $error("latched trip dropped without reset edge");
  a_power_clear: assert property (
    !resetn |=> display_code == NO_FAULT_CODE && !any_out)
    else $error("power-on reset left a fault");
  a_read_slot: assert property (disable iff (!resetn)
    !$past(reg_re) |-> reg_rdata == '0)
    else $error("read data outside its slot");
  c_halt: cover property (disable iff (!resetn) $rose(trip_halt));
  c_warn: cover property (disable iff (!resetn) $rose(warning_out));
  c_level: cover property (disable iff (!resetn)
    display_code == CW'(FI_LVT));
endmodule

// *** dv/dftm_sense_model.sv ***
/*
  Sensing circuits and operator reset seen by the trip manager.
  Assumes the bench sets the condition levels in want.
*/
`timescale 1ns/10ps
module dftm_sense_model
  import dftm_pkg::*;
#(
  parameter int RST_LEN = 3
) (
  input wire logic core_clk,
  input wire dftm_sens_s want,
  input wire logic reset_req,
  output dftm_sens_s sens_pins
);
  int hold_cnt = 0;
  // Stretched so the three-flop synchroniser cannot miss it
  always @(posedge core_clk) begin
    if (reset_req) begin
      hold_cnt <= RST_LEN;
    end else if (hold_cnt != 0) begin
      hold_cnt <= hold_cnt - 1;
    end
  end
  always_comb begin
    sens_pins = want;
    sens_pins.fault_reset = want.fault_reset | (hold_cnt != 0);
  end
endmodule

// *** dv/drive_fault_trip_manager_bench.sv ***
/*
  Self-checking bench of the drive fault-trip manager.
  Assumes dftm_pkg, dftm_top, the sense model and the checker.
*/
`timescale 1ns/10ps
module drive_fault_trip_manager_bench
  import dftm_pkg::*;
;
  localparam int MS_SIM = 10;
  localparam int LIMIT = 60000;
  localparam logic [8:0] F_RST = 9'h100;
  localparam logic [8:0] F_OC = 9'h080;
  localparam logic [8:0] F_OV = 9'h040;
  localparam logic [8:0] F_LT = 9'h020;
  localparam logic [8:0] F_RUN = 9'h010;
  localparam logic [8:0] F_UV = 9'h008;
  localparam logic [8:0] F_NM = 9'h004;
  localparam logic [8:0] F_OPO = 9'h002;
  localparam logic [8:0] F_IPO = 9'h001;
  localparam logic [7:0] MID = 8'h3c;
  logic core_clk;
  logic resetn;
  logic rst_req;
  logic reg_we;
  logic reg_re;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic trip_halt;
  logic warning_out;
  logic [CW-1:0] display_code;
  dftm_sens_s want;
  dftm_sens_s sens_pins;
  int n_fail = 0;
  int compares = 0;
  int cyc_cnt = 0;

  dftm_sense_model model_u (.core_clk(core_clk), .want(want),
    .reset_req(rst_req), .sens_pins(sens_pins));
  dftm_top #(.MS_CYCLES(MS_SIM)) dut_u (.core_clk(core_clk),
    .resetn(resetn), .sens_pins(sens_pins), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .trip_halt(trip_halt),
    .warning_out(warning_out), .display_code(display_code));

  function automatic dftm_sens_s mk(input logic [8:0] f,
      input logic [7:0] ld, input logic [7:0] cu);
    dftm_sens_s s;
    s = '0;
    {s.fault_reset, s.overcurrent, s.overvoltage, s.light_duty, s.running,
      s.undervoltage, s.motor_absent, s.out_phase_open,
      s.in_phase_open} = f;
    s.load_pct = ld;
    s.current_pct = cu;
    return s;
  endfunction

  task automatic stop_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
      input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic drv(input dftm_sens_s s);
    @(posedge core_clk);
    want <= s;
  endtask

  task automatic outs(input logic h, input logic w,
      input logic [CW-1:0] c);
    #1;
    chk("trip_halt", 32'(h), 32'(trip_halt));
    chk("warning_out", 32'(w), 32'(warning_out));
    chk("display_code", 32'(c), 32'(display_code));
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge core_clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
      input string nm);
    @(posedge core_clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge core_clk);
    reg_re <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata);
  endtask

  // Low gap first: a shorter one may be lost in the synchroniser
  task automatic pulse_reset();
    cyc(4);
    @(posedge core_clk);
    rst_req <= 1'b1;
    @(posedge core_clk);
    rst_req <= 1'b0;
    cyc(10);
  endtask

  task automatic try_src(input logic [7:0] a, input logic [31:0] d,
      input dftm_sens_s s, input logic [31:0] act, input int w);
    wr(a, 32'h0);
    drv(s);
    cyc(w);
    rd_chk(ADDR_ACT, act & 32'(CLS_LEVEL), "act_disabled");
    wr(a, d);
    cyc(w);
    rd_chk(ADDR_ACT, act, "act_enabled");
    wr(a, 32'h0);
    drv(mk(9'h0, MID, MID));
    pulse_reset();
    rd_chk(ADDR_ACT, 32'h0, "act_cleared");
  endtask

  task automatic s_reset();
    outs(1'b0, 1'b0, NO_FAULT_CODE);
    rd_chk(ADDR_HIST, 32'h000fffff, "hist_reset");
    wr(ADDR_ACT, 32'hffffffff);
    rd_chk(ADDR_ACT, 32'h0, "act_readonly");
    rd_chk(8'h20, 32'h0, "unmapped");
  endtask

  // Light duty at 200%: must hold 2000 ms, trip soon after
  task automatic s_drive();
    drv(mk(F_LT, PCT_200, MID));
    cyc((OL_T200L_MS - 100) * MS_SIM);
    rd_chk(ADDR_ACT, 32'h0, "ovl_early");
    cyc(110 * MS_SIM);
    rd_chk(ADDR_ACT, 32'h1 << FI_IOL, "ovl_trip");
    drv(mk(9'h0, MID, MID));
    cyc(400 * MS_SIM);
    pulse_reset();
    rd_chk(ADDR_ACT, 32'h0, "ovl_clear");
  endtask

  task automatic s_latch();
    drv(mk(F_OC, MID, MID));
    cyc(8);
    outs(1'b1, 1'b0, CW'(FI_OCT));
    drv(mk(9'h0, MID, MID));
    cyc(8);
    outs(1'b1, 1'b0, CW'(FI_OCT));
    drv(mk(F_RST, MID, MID));
    cyc(8);
    outs(1'b0, 1'b0, NO_FAULT_CODE);
    drv(mk(F_RST | F_OC, MID, MID));
    cyc(8);
    drv(mk(F_RST, MID, MID));
    cyc(8);
    outs(1'b1, 1'b0, CW'(FI_OCT));
    drv(mk(9'h0, MID, MID));
    pulse_reset();
    outs(1'b0, 1'b0, NO_FAULT_CODE);
  endtask

  task automatic s_level();
    drv(mk(F_UV, MID, MID));
    cyc(8);
    outs(1'b1, 1'b0, CW'(FI_LVT));
    drv(mk(9'h0, MID, MID));
    cyc(8);
    outs(1'b0, 1'b0, NO_FAULT_CODE);
    drv(mk(F_UV | F_OV, MID, MID));
    cyc(8);
    outs(1'b1, 1'b0, CW'(FI_OVT));
    drv(mk(9'h0, MID, MID));
    cyc(8);
    outs(1'b1, 1'b0, CW'(FI_OVT));
    pulse_reset();
    rd_chk(ADDR_HIST, 32'h00028001, "history");
  endtask

  task automatic s_warn();
    wr(ADDR_WARN, 32'h2);
    rd_chk(ADDR_WARN, 32'h2, "warn_mask");
    drv(mk(F_OV, MID, MID));
    cyc(8);
    outs(1'b0, 1'b1, CW'(FI_OVT));
    drv(mk(9'h0, MID, MID));
    wr(ADDR_WARN, 32'h0);
    pulse_reset();
    outs(1'b0, 1'b0, NO_FAULT_CODE);
  endtask

  // Relay check is armed only until the first millisecond tick after power-on reset
  task automatic s_relay();
    dftm_sens_s s;
    s = mk(9'h0, MID, MID);
    s.relay_fail = 1'b1;
    @(posedge core_clk);
    want <= s;
    resetn <= 1'b0;
    cyc(4);
    outs(1'b0, 1'b0, NO_FAULT_CODE);
    resetn <= 1'b1;
    wr(ADDR_CFG, 32'h10000);
    cyc(8);
    rd_chk(ADDR_ACT, 32'h1000, "relay_trip");
    wr(ADDR_CFG, 32'h0);
    drv(mk(9'h0, MID, MID));
    pulse_reset();
    rd_chk(ADDR_ACT, 32'h0, "relay_clear");
  endtask

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == LIMIT) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    resetn = 1'b0;
    rst_req = 1'b0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    want = mk(9'h0, MID, MID);
    cyc(4);
    resetn <= 1'b1;
    s_reset();
    wr(ADDR_LVL, 32'h00002864);
    s_drive();
    s_latch();
    s_level();
    s_warn();
    try_src(ADDR_EN, 32'h1, mk(0, 8'h78, MID), 32'h200, 8);
    try_src(ADDR_EN, 32'h100, mk(0, 8'h14, MID), 32'h400, 8);
    try_src(ADDR_EN, 32'h10000, mk(0, 8'h8c, MID), 32'h40, 4600);
    try_src(ADDR_EN, 32'h1000000, mk(F_RUN | F_NM, MID, MID), 32'h800,
      8);
    try_src(ADDR_CFG, 32'h1, mk(F_RUN | F_UV, MID, MID), 32'h18,
      8);
    try_src(ADDR_CFG, 32'h200, mk(F_OPO, MID, MID), 32'h80, 8);
    try_src(ADDR_CFG, 32'h400, mk(F_IPO, MID, MID), 32'h100, 8);
    try_src(ADDR_TQ, 32'h2803, mk(0, MID, 8'h78), 32'h2000, 8);
    try_src(ADDR_TQ, 32'h280040, mk(0, MID, 8'h78), 32'h4000, 8);
    try_src(ADDR_TQ, 32'h2807, mk(0, MID, 8'h14), 32'h8000, 8);
    try_src(ADDR_TQ, 32'h280080, mk(0, MID, 8'h14), 32'h10000,
      8);
    s_relay();
    stop_test();
  end
endmodule

bind dftm_top dftm_checker chk_u (.core_clk(core_clk), .resetn(resetn),
  .sens_pins(sens_pins), .reg_re(reg_re), .reg_rdata(reg_rdata),
  .trip_halt(trip_halt), .warning_out(warning_out),
  .display_code(display_code));
